// ==== inc/dsc_cfg.svh ====
// Offsets, field positions, reset values and codes of the system control and status registers.
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
`define DSC_ADDR_W          4
`define DSC_OFF_RESET_REQ   4'h8
`define DSC_OFF_SYS_CTRL    4'ha
`define DSC_OFF_SYS_STATUS  4'hb
`define DSC_OFF_CRC_STATUS  4'hc
`define DSC_RESET_SIGNATURE 8'h59
`define DSC_CTRL_CLK_BIT    0
`define DSC_CTRL_DONE_BIT   1
`define DSC_ST_LOCK_BIT     0
`define DSC_ST_UPROG_BIT    2
`define DSC_ST_NPROG_BIT    3
`define DSC_ST_SLEEP_BIT    4
`define DSC_ST_SRST_BIT     5
`define DSC_ST_EFAIL_BIT    6
`define DSC_STATUS_RESET    8'h01
`define DSC_CRC_RESET       3'h0
`define DSC_CRC_BUSY        3'h1
`define DSC_CRC_PASS        3'h2
`define DSC_CRC_FAIL        3'h4
`endif

// ==== inc/dsc_pkg.sv ====
// Types shared by the system control and status block.
package dsc_pkg;
  typedef enum logic [3:0] {
    DSC_CRC_OFF  = 4'h1,
    DSC_CRC_RUN  = 4'h2,
    DSC_CRC_OK   = 4'h4,
    DSC_CRC_BAD  = 4'h8
  } dsc_crc_state_t;
endpackage

// ==== inc/dsc_crc_if.sv ====
// Signals between the register block and the CRC status tracker.
`timescale 1ns/10ps
interface dsc_crc_if;
  logic       crc_enable;
  logic       crc_done;
  logic       crc_pass;
  logic [2:0] crc_code;
  modport tracker (input crc_enable, input crc_done, input crc_pass, output crc_code);
  modport user    (output crc_enable, output crc_done, output crc_pass, input crc_code);
endinterface

// ==== rtl/dsc_crc_track.sv ====
// One-hot CRC execution status tracker.
`timescale 1ns/10ps
`include "dsc_cfg.svh"
module dsc_crc_track
  import dsc_pkg::*;
(
  input wire logic   clk,
  input wire logic   srst,
  dsc_crc_if.tracker crc
);
  dsc_crc_state_t state_reg;
  dsc_crc_state_t state_next;
  logic [2:0]     code_reg;

  // Busy while enabled and not done; result holds until the check is disabled.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DSC_CRC_OFF: if (crc.crc_enable) state_next = DSC_CRC_RUN;
      DSC_CRC_RUN: begin
        if (!crc.crc_enable) state_next = DSC_CRC_OFF;
        else if (crc.crc_done) state_next = crc.crc_pass ? DSC_CRC_OK : DSC_CRC_BAD;
      end
      DSC_CRC_OK, DSC_CRC_BAD: if (!crc.crc_enable) state_next = DSC_CRC_OFF;
      default: state_next = DSC_CRC_OFF;
    endcase
  end

  // The code is registered so the status read never sees a decode glitch.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= DSC_CRC_OFF;
      code_reg  <= `DSC_CRC_RESET;
    end else begin
      state_reg <= state_next;
      case (state_next)
        DSC_CRC_RUN: code_reg <= `DSC_CRC_BUSY;  // see RULE_15
        DSC_CRC_OK:  code_reg <= `DSC_CRC_PASS;  // see RULE_15
        DSC_CRC_BAD: code_reg <= `DSC_CRC_FAIL;  // see RULE_15
        default:     code_reg <= `DSC_CRC_RESET;
      endcase
    end
  end

  assign crc.crc_code = code_reg;
endmodule // dsc_crc_track

// ==== rtl/dsc_sys_ctrl.sv ====
// System control and status registers of the debug port access layer.
// How it works
// (RULE_01) Writing user row done starts flash programming.
// (RULE_02) User row done writable only with key.
// (RULE_03) Early done write: processor continues without data.
// (RULE_04) Tool writes done after staging all data.
// (RULE_05) Clock request holds clock through sleep.
// (RULE_06) Writing zero withdraws the clock request.
// (RULE_07) Port enable sets clock request automatically.
// (RULE_08) Erase failed set on failure, reset clears.
// (RULE_09) Reset active flag tracks reset, clears on read.
// (RULE_10) Sleeping flag shows idle or deeper sleep.
// (RULE_11) NVM programming ready flag when allowed.
// (RULE_12) Tool resets system after NVM programming.
// (RULE_13) User row ready flag when allowed.
// (RULE_14) Locked flag follows device lock state.
// (RULE_15) CRC status is one-hot coded.
// (RULE_16) System status resets to locked only.
// (RULE_17) Signature write holds system reset, else releases.
// (RULE_18) Tool writes key status last in session.
// (RULE_19) Read-only writes ignored, reserved bits zero.
`timescale 1ns/10ps
`include "dsc_cfg.svh"
module dsc_sys_ctrl
  import dsc_pkg::*;
#(
  parameter int ADDR_W = `DSC_ADDR_W
)
(
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   port_enable,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [7:0]             reg_wdata,
  output logic      [7:0]             reg_rdata,
  input  wire logic                   user_row_key_status,
  input  wire logic                   user_row_staged,
  input  wire logic                   sys_in_reset,
  input  wire logic                   sys_sleep,
  input  wire logic                   nvm_prog_allowed,
  input  wire logic                   user_row_prog_allowed,
  input  wire logic                   lock_state,
  input  wire logic                   erase_fail_event,
  input  wire logic                   crc_enable,
  input  wire logic                   crc_done,
  input  wire logic                   crc_pass,
  output logic                        sys_clock_request,
  output logic                        user_row_prog_start,
  output logic                        user_row_data_valid,
  output logic                        system_reset_hold
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration check. The register offsets are four bits wide, so a narrower
  // address bus could not reach the status registers; a wider one is fine, the
  // upper address bits must simply be zero for a hit.
  if (ADDR_W < `DSC_ADDR_W) begin : g_addr_w_check
    $error("dsc_sys_ctrl: address width too small for the register map");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Synchronise the system-domain status levels; they come from another domain.
  // Each level passes two flip-flops before any logic reads it. The levels are
  // synchronised one by one, not as a word: every bit has a meaning of its own,
  // so a skew of one cycle between two flags is harmless to the tool reading them.
  // Limitation: a pulse on a level input shorter than one clock may be missed.
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign raw_in = {port_enable,            // Bit 7: debug port enabled.
                   erase_fail_event,       // Bit 6: chip erase failed.
                   lock_state,             // Bit 5: device locked.
                   user_row_prog_allowed,  // Bit 4: user row programming may begin.
                   nvm_prog_allowed,       // Bit 3: NVM programming may begin.
                   sys_sleep,              // Bit 2: system domain asleep.
                   sys_in_reset,           // Bit 1: system domain in reset.
                   user_row_staged};       // Bit 0: user row data staged in RAM.

  // Both stages clear on reset, so all flags read low until the levels settle.
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Synchronised copies; only these are read by the logic below.
  wire logic s_staged = sync2_reg[0];
  wire logic s_rst    = sync2_reg[1];
  wire logic s_sleep  = sync2_reg[2];
  wire logic s_nprog  = sync2_reg[3];
  wire logic s_uprog  = sync2_reg[4];
  wire logic s_lock   = sync2_reg[5];
  wire logic s_efail  = sync2_reg[6];
  wire logic s_en     = sync2_reg[7];

  //////////////////////////////////////////////////////////////////////////////
  // Address decode. Only full matches count, so an unmapped offset never aliases
  // onto a register and its writes simply fall away.
  // The function is shared by the write and status-read decodes so those offsets compare the same way.
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  wire logic wr_req    = reg_wr && hit(reg_addr, ADDR_W'(`DSC_OFF_RESET_REQ));
  wire logic wr_ctrl   = reg_wr && hit(reg_addr, ADDR_W'(`DSC_OFF_SYS_CTRL));
  wire logic rd_status = reg_rd && hit(reg_addr, ADDR_W'(`DSC_OFF_SYS_STATUS));

  //////////////////////////////////////////////////////////////////////////////
  // Control register and reset request. The done bit is not stored: it acts as a
  // strobe, so it always reads back as zero and cannot start programming twice.
  // The reset hold lives here too: it is the only state the reset request keeps.
  logic en_d_reg;
  logic clk_req_reg;
  logic start_reg;
  logic valid_reg;
  logic hold_reg;
  logic efail_reg;
  logic srst_flag_reg;
  logic [7:0] rdata_reg;

  // Decoded events of this cycle; each feeds the registers below.
  wire logic en_rise  = s_en && !en_d_reg;
  wire logic done_wr  = wr_ctrl && reg_wdata[`DSC_CTRL_DONE_BIT] && user_row_key_status;  // see RULE_02
  wire logic in_reset = s_rst || hold_reg;

  // The enable edge beats a simultaneous write so the port never loses its clock on wake.
  // The edge is taken from the synchronised level, so it lags the pin by two cycles;
  // a control write in the very cycle of the edge is overruled by the automatic set.
  always_ff @(posedge clk) begin
    if (srst) begin
      en_d_reg    <= 1'b0;
      clk_req_reg <= 1'b0;
      start_reg   <= 1'b0;
      valid_reg   <= 1'b0;
      hold_reg    <= 1'b0;
    end else begin
      en_d_reg <= s_en;
      if (en_rise) clk_req_reg <= 1'b1;  // see RULE_07
      else if (wr_ctrl) clk_req_reg <= reg_wdata[`DSC_CTRL_CLK_BIT];  // see RULE_05 RULE_06
      start_reg <= done_wr;  // see RULE_01
      valid_reg <= done_wr && s_staged;  // see RULE_03
      if (wr_req) hold_reg <= (reg_wdata == `DSC_RESET_SIGNATURE);  // see RULE_17
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status flags. A new event beats a clear in the same cycle.
  // The reset-active flag is cleared by the read that reports it, so the tool sees
  // every reset at least once, even one shorter than the time between two reads.
  always_ff @(posedge clk) begin
    if (srst) begin
      efail_reg     <= 1'b0;
      srst_flag_reg <= 1'b0;
    end else begin
      if (s_efail) efail_reg <= 1'b1;  // see RULE_08
      else if (in_reset) efail_reg <= 1'b0;  // see RULE_08
      if (in_reset) srst_flag_reg <= 1'b1;  // see RULE_09
      else if (rd_status) srst_flag_reg <= 1'b0;  // see RULE_09
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data; status and CRC registers have no write path at all.
  // The CRC status tracker sits in its own module and talks over an interface.
  logic [7:0] status_val;
  logic [7:0] rd_mux;
  dsc_crc_if  crc_bus ();
  assign crc_bus.crc_enable = crc_enable;
  assign crc_bus.crc_done   = crc_done;
  assign crc_bus.crc_pass   = crc_pass;

  // The tracker registers its code from the next state, so a CRC result reaches a read at the same edge as the state, with no extra cycle.
  dsc_crc_track u_crc (
    .clk  (clk),
    .srst (srst),
    .crc  (crc_bus.tracker)
  );

  // Status byte assembly; bits without a flag stay zero.
  always_comb begin
    status_val = 8'h00;  // see RULE_19
    status_val[`DSC_ST_LOCK_BIT]  = s_lock;  // see RULE_14
    status_val[`DSC_ST_UPROG_BIT] = s_uprog;  // see RULE_13
    status_val[`DSC_ST_NPROG_BIT] = s_nprog;  // see RULE_11
    status_val[`DSC_ST_SLEEP_BIT] = s_sleep;  // see RULE_10
    status_val[`DSC_ST_SRST_BIT]  = srst_flag_reg;
    status_val[`DSC_ST_EFAIL_BIT] = efail_reg;
  end

  // Register select for the read port; unmapped offsets read zero.
  always_comb begin
    case (reg_addr)
      ADDR_W'(`DSC_OFF_RESET_REQ):  rd_mux = {7'h00, hold_reg};
      ADDR_W'(`DSC_OFF_SYS_CTRL):   rd_mux = {6'h00, 1'b0, clk_req_reg};
      ADDR_W'(`DSC_OFF_SYS_STATUS): rd_mux = status_val;
      ADDR_W'(`DSC_OFF_CRC_STATUS): rd_mux = {5'h00, crc_bus.crc_code};  // see RULE_19
      default:             rd_mux = 8'h00;
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  // Holding it lets the tool sample at leisure; the reset value is the status reset.
  always_ff @(posedge clk) begin
    if (srst) rdata_reg <= `DSC_STATUS_RESET;  // see RULE_16
    else if (reg_rd) rdata_reg <= rd_mux;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs. Every one comes straight from a flip-flop, so none can glitch.
  // The start and valid pulses last as long as the qualifying control write, one clock behind it.
  assign reg_rdata           = rdata_reg;
  assign sys_clock_request   = clk_req_reg;
  assign user_row_prog_start = start_reg;
  assign user_row_data_valid = valid_reg;
  assign system_reset_hold   = hold_reg;

endmodule // dsc_sys_ctrl

// ==== test/dsc_sys_ctrl_props.sv ====
// Port checker of the system control and status block.
`timescale 1ns/10ps
`include "dsc_cfg.svh"
module dsc_sys_ctrl_props (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       port_enable,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       user_row_key_status,
  input wire logic       sys_clock_request,
  input wire logic       user_row_prog_start,
  input wire logic       system_reset_hold
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Decoded writes; the key must be present in the very cycle of the write.
  wire ctl_wr = reg_wr && reg_addr == `DSC_OFF_SYS_CTRL;
  wire rst_wr = reg_wr && reg_addr == `DSC_OFF_RESET_REQ;
  AST_START: assert property (ctl_wr && reg_wdata[1] && user_row_key_status |=> user_row_prog_start)
    else $error("start missing");
  AST_NOKEY: assert property (user_row_prog_start |-> $past(ctl_wr && reg_wdata[1] && user_row_key_status))
    else $error("start without keyed write");
  AST_CLKSET: assert property (ctl_wr && reg_wdata[0] |=> sys_clock_request)
    else $error("clock request not set");
  AST_CLKCLR: assert property (ctl_wr && !reg_wdata[0] && ($past(port_enable, 2) == $past(port_enable, 3))
                               |=> !sys_clock_request)
    else $error("clock request not withdrawn");
  AST_ENSET: assert property ($rose(port_enable) |-> ##[1:5] sys_clock_request)
    else $error("enable did not set clock request");
  AST_HOLD: assert property (rst_wr |=> system_reset_hold == ($past(reg_wdata) == `DSC_RESET_SIGNATURE))
    else $error("reset hold wrong");
  AST_CRC: assert property (reg_rd && reg_addr == `DSC_OFF_CRC_STATUS |=> $onehot0(reg_rdata))
    else $error("crc status not one-hot");
  AST_RSV: assert property (reg_rd && reg_addr == `DSC_OFF_SYS_STATUS |=> !reg_rdata[7] && !reg_rdata[1])
    else $error("reserved status bit set");
  // Main scenarios reached.
  cover property (user_row_prog_start);
  cover property (system_reset_hold);
  cover property ($fell(sys_clock_request));
endmodule // dsc_sys_ctrl_props
bind dsc_sys_ctrl dsc_sys_ctrl_props u_props (.*);

// ==== test/dsc_tool.sv ====
// Programmer-side model issuing register writes and reads.
`timescale 1ns/10ps
module dsc_tool (
  input  wire logic       clk,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic [3:0]      reg_addr = 4'h0,
  output logic [7:0]      reg_wdata = 8'h00,
  input  wire logic [7:0] reg_rdata
);
  // Request held through its taking edge; released lines show inverted values, not stale ones.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  // Read data is settled one step after the taking edge.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata;
  endtask
endmodule // dsc_tool

// ==== test/dsc_sys_ctrl_bench.sv ====
// Self-checking bench of the system control and status block.
`timescale 1ns/10ps
`include "dsc_cfg.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module dsc_sys_ctrl_bench;
  logic       clk = 0, srst = 1, port_enable = 0, key = 0, crc_enable = 0, crc_done = 0, crc_pass = 0;
  logic [6:0] sysin = 7'h20; // Erase, lock, user row, nvm, sleep, in reset, staged.
  wire        reg_wr, reg_rd, clk_req, start, dvalid, hold;
  wire [3:0]  reg_addr;
  wire [7:0]  reg_wdata, reg_rdata;
  logic [7:0] d;
  int         err_count = 0, tests_run = 0, cycles = 0;
  dsc_tool tool (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  dsc_sys_ctrl DUT (.clk(clk), .srst(srst), .port_enable(port_enable), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .user_row_key_status(key),
    .user_row_staged(sysin[0]), .sys_in_reset(sysin[1]), .sys_sleep(sysin[2]), .nvm_prog_allowed(sysin[3]),
    .user_row_prog_allowed(sysin[4]), .lock_state(sysin[5]), .erase_fail_event(sysin[6]),
    .crc_enable(crc_enable), .crc_done(crc_done), .crc_pass(crc_pass), .sys_clock_request(clk_req),
    .user_row_prog_start(start), .user_row_data_valid(dvalid), .system_reset_hold(hold));
  // Clock, and a ceiling well above the roughly 130 cycles the tests take.
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Read a register and compare it; asynchronous inputs get three cycles to pass the synchronisers.
  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string nm);
    repeat (3) @(posedge clk);
    tool.rd(a, d);
    `CHK(nm, e, d)
  endtask
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    #1 srst = 0;
    `CHK("rdata_rst", 8'h01, reg_rdata)
    rdc(4'hb, 8'h01, "status_rst");
    rdc(4'hc, 8'h00, "crc_rst");
    tool.wr(4'hb, 8'hfe);
    rdc(4'hb, 8'h01, "status_ro");
    rdc(4'h3, 8'h00, "unmapped");
    sysin = 7'h1c;
    rdc(4'hb, 8'h1c, "flags");
    sysin = 7'h02;
    rdc(4'hb, 8'h20, "in_reset");
    sysin = 7'h40;
    rdc(4'hb, 8'h60, "erase_fail");
    sysin = 7'h00;
    rdc(4'hb, 8'h40, "rst_read_clear");
    tool.wr(4'h8, 8'h59);
    `CHK("hold_on", 1'b1, hold)
    rdc(4'h8, 8'h01, "hold_rd");
    rdc(4'hb, 8'h20, "held");
    tool.wr(4'h8, 8'h5a);
    `CHK("hold_off", 1'b0, hold)
    rdc(4'hb, 8'h20, "rst_seen");
    rdc(4'hb, 8'h00, "rst_gone");
    port_enable = 1;
    repeat (5) @(posedge clk);
    #1;
    `CHK("clk_req_en", 1'b1, clk_req)
    tool.wr(4'ha, 8'h00);
    `CHK("clk_req_off", 1'b0, clk_req)
    rdc(4'ha, 8'h00, "ctrl_off");
    sysin = 7'h04;
    tool.wr(4'ha, 8'h03);
    `CHK("nokey", 2'b00, {start, dvalid})
    `CHK("clk_req_sleep", 1'b1, clk_req)
    rdc(4'ha, 8'h01, "ctrl_on");
    key = 1;
    tool.wr(4'ha, 8'h03);
    `CHK("early_done", 2'b10, {start, dvalid})
    sysin = 7'h05;
    repeat (3) @(posedge clk);
    tool.wr(4'ha, 8'h03);
    `CHK("done", 2'b11, {start, dvalid})
    key = 0;
    for (int i = 0; i < 2; i++) begin
      crc_enable = 1;
      rdc(4'hc, 8'h01, "crc_busy");
      crc_pass = i[0];
      crc_done = 1;
      @(posedge clk);
      #1 crc_done = 0;
      rdc(4'hc, i ? 8'h02 : 8'h04, "crc_result");
      crc_enable = 0;
      rdc(4'hc, 8'h00, "crc_off");
    end
    give_verdict();
  end
endmodule // dsc_sys_ctrl_bench
